// >>> design/tpf_formatter.sv
/*
 Terminal port formatter: framing, echo, line formatting, mode switching
 and packet triggering between a host serial port and the packet engine.
 Assumes the serial shifter gives/takes whole characters with bit counts,
 and that the packet engine reports link up/down as clocked levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tpf_regs.svh"
module tpf_formatter #(
   parameter int BAUD_CYC = 26042   // MCLK cycles per serial bit
) (
   // Clock and reset
   input  wire logic            MCLK,
   input  wire logic            RST_B,
   // Settings
   input  wire tpf_pkg::tpf_frame_t FRAME,
   input  wire tpf_pkg::tpf_fmt_t   FMT,
   input  wire logic [7:0]      ESC_CHAR,
   input  wire logic [7:0]      SEND_CHAR,
   input  wire logic            ENTER_TALK_MODE,
   // Host receive side: raw frame of data and parity bits from pin shifter
   input  wire logic            RX_VALID,
   input  wire logic [8:0]      RX_FRAME,
   input  wire logic            RX_BREAK,
   // Host transmit side
   output logic                 TX_VALID,
   output logic [8:0]           TX_FRAME,
   input  wire logic            TX_READY,
   // Packet side
   output logic                 PKT_VALID,
   output logic [7:0]           PKT_DATA,
   output logic                 PKT_CLOSE,
   output logic                 PKT_BROADCAST,
   input  wire logic            LINK_UP,
   // Status
   output logic                 LINK_UP_LAMP,
   output logic                 TALK_MODE,
   output logic                 RX_PARITY_ERR
);
   // Elaboration check: a bit needs at least one clock
   if (BAUD_CYC < 1) begin : g_bad_baud
      $error("BAUD_CYC must be positive");
   end
   // ====================================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) rst_sync <= 2'h0;
      else        rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];
   logic brk_s0;
   logic brk_s1;
   logic brk_d;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         brk_s0 <= 1'b0;
         brk_s1 <= 1'b0;
         brk_d  <= 1'b0;
      end else begin
         brk_s0 <= RX_BREAK;
         brk_s1 <= brk_s0;
         brk_d  <= brk_s1;
      end
   end
   logic brk_rise;
   assign brk_rise = brk_s1 & ~brk_d;
   // ====================================================================
   // Framing helpers
   // Data bits kept, top bit cleared for 7-bit words
   function automatic logic [7:0] data_of(input logic [8:0] f,
                                          input logic w8);
      data_of = w8 ? f[7:0] : {1'b0, f[6:0]};
   endfunction : data_of
   // Parity over configured data bits only
   function automatic logic par_of(input logic [7:0] d,
                                   input logic [1:0] p);
      par_of = (^d) ^ (p == `TPF_PAR_ODD);
   endfunction : par_of
   // Build transmit frame: parity bit just above the data
   function automatic logic [8:0] frame_of(input logic [7:0] d,
                                           input tpf_pkg::tpf_frame_t f);
      logic pb;
      pb = par_of(f.wlen8 ? d : {1'b0, d[6:0]}, f.parity);
      if (f.parity == `TPF_PAR_NONE)
         frame_of = f.wlen8 ? {1'b0, d} : {2'h0, d[6:0]};
      else if (f.wlen8)
         frame_of = {pb, d};
      else
         frame_of = {1'b0, pb, d[6:0]};
   endfunction : frame_of
   logic [7:0] rx_ch;
   logic       rx_pbit;
   assign rx_ch   = data_of(RX_FRAME, FRAME.wlen8);
   assign rx_pbit = FRAME.wlen8 ? RX_FRAME[8] : RX_FRAME[7];
   // Parity check, sticky until a clean character
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) RX_PARITY_ERR <= 1'b0;
      else if (RX_VALID && FRAME.parity != `TPF_PAR_NONE)
         RX_PARITY_ERR <= rx_pbit != par_of(rx_ch, FRAME.parity);
   end
   // ====================================================================
   // Mode control
   tpf_pkg::tpf_mode_t mode;
   logic link_d;
   logic esc_hit;
   assign esc_hit = (RX_VALID && rx_ch == ESC_CHAR
                     && mode == tpf_pkg::TPF_TALK)
                    || brk_rise;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         mode   <= tpf_pkg::TPF_CMD;
         link_d <= 1'b0;
      end else begin
         link_d <= LINK_UP;
         if (esc_hit) mode <= tpf_pkg::TPF_CMD;
         else if (LINK_UP && !link_d) mode <= tpf_pkg::TPF_TALK;
         else if (ENTER_TALK_MODE) mode <= tpf_pkg::TPF_TALK;
      end
   end
   // Lamp and mode flag from flops
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         LINK_UP_LAMP <= 1'b0;
         TALK_MODE    <= 1'b0;
      end else begin
         LINK_UP_LAMP <= LINK_UP;
         TALK_MODE    <= (mode == tpf_pkg::TPF_TALK);
      end
   end
   // ====================================================================
   // Packetizer: converse-mode text goes out; send character closes it
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         PKT_VALID     <= 1'b0;
         PKT_DATA      <= 8'h00;
         PKT_CLOSE     <= 1'b0;
         PKT_BROADCAST <= 1'b1;
      end else begin
         PKT_VALID <= RX_VALID && !esc_hit && mode == tpf_pkg::TPF_TALK;
         PKT_CLOSE <= RX_VALID && !esc_hit && mode == tpf_pkg::TPF_TALK
                      && rx_ch == SEND_CHAR;
         PKT_DATA  <= rx_ch;
         PKT_BROADCAST <= !LINK_UP;
      end
   end
   // ====================================================================
   // Output request flags: set wins over clear by ordering
   logic req_echo;
   logic [7:0] echo_ch;
   logic req_prompt;
   logic req_up;
   logic req_dn;
   logic take_echo;
   logic take_prompt;
   logic take_up;
   logic take_dn;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         req_echo   <= 1'b0;
         echo_ch    <= 8'h00;
         req_prompt <= 1'b1;  // Prompt at start in command mode
         req_up     <= 1'b0;
         req_dn     <= 1'b0;
      end else begin
         if (take_echo) req_echo <= 1'b0;
         if (RX_VALID && !esc_hit) begin
            req_echo <= 1'b1;
            echo_ch  <= rx_ch;
         end
         if (take_prompt) req_prompt <= 1'b0;
         // Command line done or escape: show prompt
         if (esc_hit || (RX_VALID && mode == tpf_pkg::TPF_CMD
                         && rx_ch == `TPF_CH_CR))
            req_prompt <= 1'b1;
         if (take_up) req_up <= 1'b0;
         if (LINK_UP && !link_d) req_up <= 1'b1;
         if (take_dn) req_dn <= 1'b0;
         if (!LINK_UP && link_d) req_dn <= 1'b1;
      end
   end
   // ====================================================================
   // Output sequencer with line wrap, auto linefeed and padding
   tpf_pkg::tpf_ost_t ost;
   logic [7:0]  cur_ch;
   logic [7:0]  col;
   logic        lf_pend;
   logic [31:0] pad_left;
   logic [31:0] char_cyc;
   // Character time follows current framing: start, data, parity, stop
   assign char_cyc = 32'(BAUD_CYC) * ((FRAME.wlen8 ? 32'd10 : 32'd9)
                     + (FRAME.parity != `TPF_PAR_NONE ? 32'd1 : 32'd0));
   logic wrap_now;
   assign wrap_now = FMT.line_width != 8'h00 && col >= FMT.line_width;
   assign take_echo   = ost == tpf_pkg::TPF_O_IDLE && !lf_pend && !wrap_now
                        && req_echo;
   assign take_prompt = ost == tpf_pkg::TPF_O_IDLE && !lf_pend && !wrap_now
                        && !req_echo && req_prompt;
   assign take_up = ost == tpf_pkg::TPF_O_IDLE && !lf_pend && !wrap_now
                    && !req_echo && !req_prompt && req_up;
   assign take_dn = ost == tpf_pkg::TPF_O_IDLE && !lf_pend && !wrap_now
                    && !req_echo && !req_prompt && !req_up && req_dn;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ost      <= tpf_pkg::TPF_O_IDLE;
         cur_ch   <= 8'h00;
         col      <= 8'h00;
         lf_pend  <= 1'b0;
         pad_left <= 32'h0;
         TX_VALID <= 1'b0;
         TX_FRAME <= 9'h000;
      end else begin
         case (ost)
            tpf_pkg::TPF_O_IDLE: begin
               ost <= tpf_pkg::TPF_O_SEND;
               if (lf_pend) begin
                  cur_ch  <= `TPF_CH_LF;
                  lf_pend <= 1'b0;
               end else if (wrap_now) cur_ch <= `TPF_CH_CR;
               else if (take_echo)   cur_ch <= echo_ch;
               else if (take_prompt) cur_ch <= `TPF_CH_PROMPT;
               else if (take_up)     cur_ch <= `TPF_CH_LINKUP;
               else if (take_dn)     cur_ch <= `TPF_CH_LINKDN;
               else ost <= tpf_pkg::TPF_O_IDLE;
            end
            tpf_pkg::TPF_O_SEND: begin
               TX_VALID <= 1'b1;
               TX_FRAME <= frame_of(cur_ch, FRAME);
               ost      <= tpf_pkg::TPF_O_WAIT;
            end
            tpf_pkg::TPF_O_WAIT: begin
               if (TX_READY) begin
                  TX_VALID <= 1'b0;
                  if (cur_ch == `TPF_CH_CR) begin
                     col     <= 8'h00;
                     lf_pend <= FMT.auto_linefeed;
                  end else if (cur_ch != `TPF_CH_LF) col <= col + 8'h01;
                  pad_left <= 32'(FMT.pad_count) * char_cyc;
                  if ((cur_ch == `TPF_CH_CR && FMT.pad_after_return) ||
                      (cur_ch == `TPF_CH_LF && FMT.pad_after_linefeed))
                     ost <= tpf_pkg::TPF_O_PAD;
                  else
                     ost <= tpf_pkg::TPF_O_IDLE;
               end
            end
            tpf_pkg::TPF_O_PAD: begin
               if (pad_left <= 32'h1) ost <= tpf_pkg::TPF_O_IDLE;
               pad_left <= pad_left - 32'h1;
            end
            default: ost <= tpf_pkg::TPF_O_IDLE;
         endcase
      end
   end
   // ====================================================================
   // Checks
   sequence s_cr_out;
      TX_VALID && TX_READY && TX_FRAME[6:0] == `TPF_CH_CR;
   endsequence
   chk_auto_linefeed_follows: assert property (@(posedge MCLK) disable iff (!rst_n)
      s_cr_out and (FMT.auto_linefeed && !FMT.pad_after_return)
      |-> ##[1:4] TX_VALID && TX_FRAME[6:0] == `TPF_CH_LF)
      else $error("linefeed did not follow return");
   chk_escape_cmd: assert property (@(posedge MCLK) disable iff (!rst_n)
      esc_hit |=> mode == tpf_pkg::TPF_CMD && req_prompt)
      else $error("escape did not enter command mode");
   chk_link_talk: assert property (@(posedge MCLK) disable iff (!rst_n)
      LINK_UP && !link_d && !esc_hit |=> mode == tpf_pkg::TPF_TALK)
      else $error("link up did not enter converse mode");
   chk_pkt_close: assert property (@(posedge MCLK) disable iff (!rst_n)
      RX_VALID && !esc_hit && mode == tpf_pkg::TPF_TALK
      && rx_ch == SEND_CHAR |=> PKT_CLOSE && PKT_VALID)
      else $error("send character did not close packet");
   chk_echo_req: assert property (@(posedge MCLK) disable iff (!rst_n)
      RX_VALID && !esc_hit |=> req_echo && echo_ch == $past(rx_ch))
      else $error("received character not queued for echo");
   chk_wrap_zero: assert property (@(posedge MCLK) disable iff (!rst_n)
      FMT.line_width == 8'h00 && ost == tpf_pkg::TPF_O_IDLE && !lf_pend
      && !req_echo && !req_prompt && !req_up && !req_dn
      |=> ost == tpf_pkg::TPF_O_IDLE)
      else $error("wrap with zero width");
   chk_lamp_link: assert property (@(posedge MCLK) disable iff (!rst_n)
      ##1 LINK_UP_LAMP == $past(LINK_UP))
      else $error("lamp does not follow link");
   chk_pad_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
      ost == tpf_pkg::TPF_O_PAD && pad_left > 32'h1
      |=> ost == tpf_pkg::TPF_O_PAD && !TX_VALID)
      else $error("pad ended early");
   chk_bcast_dest: assert property (@(posedge MCLK) disable iff (!rst_n)
      ##1 PKT_BROADCAST == !$past(LINK_UP))
      else $error("wrong destination choice");
   chk_frame_8n: assert property (@(posedge MCLK) disable iff (!rst_n)
      TX_VALID && FRAME.wlen8 && FRAME.parity == `TPF_PAR_NONE
      && $stable(FRAME) |-> !TX_FRAME[8])
      else $error("unexpected ninth bit");
endmodule : tpf_formatter
`default_nettype wire

// >>> include/tpf_regs.svh
/*
 Constants of the terminal port formatter: reset settings, character codes
 and timing figures. Assumes a 250 MHz MCLK.
*/
// Function
// - After reset, characters are eight data bits without parity.
// - Word length setting picks seven or eight data bits, both directions.
// - Parity code: 0 none, 1 odd, 3 even, used with word length.
// - Every character received from host, except an escape in converse mode, is echoed back once.
// - Auto linefeed on: each sent return is followed by linefeed.
// - Line width defaults to 80; full line gets return inserted.
// - Line width zero disables wrap; other values set wrap column.
// - Pad after return or linefeed pauses output when enabled.
// - Pause length is pad count times one character time.
// - Link completion switches command mode to converse, no prompt.
// - In converse mode the send character closes text into packet.
// - Packet goes to connected station, else broadcast destination.
// - Escape or break is not echoed; command mode, prompt at once.
// - Enter talk mode command returns to converse, connected or not.
// - Mode escape character is programmable.
// - Send-packet character is programmable, return by default.
// - Lamp lit while linked; link up and down reported to host.
// - In command mode ready for a line, prompt string is output.
`ifndef TPF_REGS_SVH
`define TPF_REGS_SVH
`define TPF_RST_WLEN8   1'b1
`define TPF_RST_PARITY  2'h0
`define TPF_PAR_NONE    2'h0
`define TPF_PAR_ODD     2'h1
`define TPF_PAR_EVEN    2'h3
`define TPF_RST_WIDTH   8'h50
`define TPF_RST_ESC     8'h03
`define TPF_RST_SEND    8'h0D
`define TPF_CH_CR       8'h0D
`define TPF_CH_LF       8'h0A
`define TPF_CH_PROMPT   8'h3E
`define TPF_CH_LINKUP   8'h2B
`define TPF_CH_LINKDN   8'h2D
`define TPF_CLK_MHZ     250
`endif

// >>> include/tpf_pkg.sv
/*
 Types of the terminal port formatter. Assumes nothing beyond the header.
*/
package tpf_pkg;
   // Serial framing settings
   typedef struct packed {
      logic       wlen8;
      logic [1:0] parity;
   } tpf_frame_t;
   // Line formatting settings
   typedef struct packed {
      logic       auto_linefeed;
      logic [7:0] line_width;
      logic       pad_after_return;
      logic       pad_after_linefeed;
      logic [7:0] pad_count;
   } tpf_fmt_t;
   typedef enum logic [0:0] {TPF_CMD, TPF_TALK} tpf_mode_t;
   typedef enum logic [2:0] {
      TPF_O_IDLE, TPF_O_SEND, TPF_O_WAIT, TPF_O_PAD
   } tpf_ost_t;
endpackage : tpf_pkg

// >>> dv/tpf_host_model.sv
/*
 Host-side model: sends characters to the formatter and takes its output
 frames, logging each with its cycle. Assumes one clock shared with it.
*/
`timescale 1ns/1ps
`default_nettype none
module tpf_host_model (
   // Clock
   input  wire logic       mclk,
   // Characters to the formatter
   output logic            rx_valid,
   output logic [8:0]      rx_frame,
   output logic            rx_break,
   // Characters from the formatter
   input  wire logic       tx_valid,
   input  wire logic [8:0] tx_frame,
   output logic            tx_ready
);
   // =====
   // Output log
   logic [8:0] got[$];
   int         tq[$];
   int         cyc    = 0;
   int         wait_n = 0;
   int         stall  = 2;
   initial begin
      rx_valid = 1'b0;
      rx_frame = 9'h1FF;
      rx_break = 1'b0;
      tx_ready = 1'b0;
   end
   // A frame is taken where valid and ready meet
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready) begin
         got.push_back(tx_frame);
         tq.push_back(cyc);
      end
   end
   // Slow ready, so the formatter must hold its frame
   always @(negedge mclk) begin
      if (tx_ready) begin
         tx_ready = 1'b0;
         wait_n = 0;
      end else if (tx_valid) begin
         if (wait_n >= stall) tx_ready = 1'b1;
         else wait_n++;
      end
   end
   // One character for one cycle; idle line shows the inverse
   task automatic send(input logic [8:0] f);
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_frame = f;
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_frame = ~f;
   endtask : send
   // Break held long enough to cross the synchroniser
   task automatic brk();
      @(negedge mclk) rx_break = 1'b1;
      repeat (4) @(negedge mclk);
      rx_break = 1'b0;
   endtask : brk
endmodule : tpf_host_model
`default_nettype wire

// >>> dv/tpf_formatter_bench.sv
/*
 Self-checking bench of the terminal port formatter with a host model.
 Assumes BAUD_CYC of 4, so one plain character time is 40 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tpf_regs.svh"
module tpf_formatter_bench;
   // =====
   // Wiring
   logic                mclk = 1'b0;
   logic                rst_b = 1'b0;
   tpf_pkg::tpf_frame_t frm;
   tpf_pkg::tpf_fmt_t   fmt;
   // Parity-free case first: the error flag only updates while parity is on
   tpf_pkg::tpf_frame_t cfg[4] = '{3'h0, 3'h5, 3'h3, 3'h1};
   logic [7:0]          esc, snd, pd;
   logic                talk_cmd = 1'b0;
   logic                link = 1'b0;
   logic                rxv, rxb, txv, txr, pv, pc, pb, lamp, tm, perr;
   logic [8:0]          rxf, txf;
   logic [9:0]          pq[$];
   int                  miscompares = 0;
   int                  cmp_count = 0;
   int                  i;
   // Clock of 4 ns
   always #2 mclk = ~mclk;
   tpf_formatter #(.BAUD_CYC(4)) u_dut (
      .MCLK(mclk), .RST_B(rst_b), .FRAME(frm), .FMT(fmt),
      .ESC_CHAR(esc), .SEND_CHAR(snd), .ENTER_TALK_MODE(talk_cmd),
      .RX_VALID(rxv), .RX_FRAME(rxf), .RX_BREAK(rxb),
      .TX_VALID(txv), .TX_FRAME(txf), .TX_READY(txr),
      .PKT_VALID(pv), .PKT_DATA(pd), .PKT_CLOSE(pc),
      .PKT_BROADCAST(pb), .LINK_UP(link), .LINK_UP_LAMP(lamp),
      .TALK_MODE(tm), .RX_PARITY_ERR(perr));
   tpf_host_model u_host (.mclk(mclk), .rx_valid(rxv), .rx_frame(rxf),
      .rx_break(rxb), .tx_valid(txv), .tx_frame(txf), .tx_ready(txr));
   // Packet bytes logged with destination and close marks
   always @(posedge mclk) if (pv === 1'b1) pq.push_back({pb, pc, pd});
   // =====
   // Helpers
   function automatic logic [8:0] enc(input logic [7:0] c);
      logic par;
      par = frm.wlen8 ? ^c : ^c[6:0];
      if (frm.parity == `TPF_PAR_ODD) par = ~par;
      enc = frm.wlen8 ? {par, c} : {1'b0, par, c[6:0]};
   endfunction : enc
   // Only the configured bits of a frame are meaningful
   function automatic logic [8:0] msk();
      msk = frm.wlen8 ? 9'h0FF : 9'h07F;
      if (frm.parity != `TPF_PAR_NONE) msk = {msk[7:0], 1'b1};
   endfunction : msk
   task automatic cmp_f(input logic [8:0] g, input logic [8:0] e);
      cmp_count++;
      if ((g & msk()) !== (e & msk())) begin
         miscompares++;
         $display("wrong value at %0t: frame %h, want %h", $time, g, e);
      end
   endtask : cmp_f
   task automatic cmp_v(input logic [9:0] g, e, input string m);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: %s %h, want %h", $time, m, g, e);
      end
   endtask : cmp_v
   task automatic out(input logic [7:0] c);
      logic [8:0] g;
      g = 'x;
      if (u_host.got.size() > 0) g = u_host.got.pop_front();
      cmp_f(g, enc(c));
   endtask : out
   task automatic pkt(input logic [9:0] e);
      logic [9:0] g;
      g = 'x;
      if (pq.size() > 0) g = pq.pop_front();
      if (e[8]) g[7:0] = e[7:0]; // Byte on a close is not defined
      cmp_v(g, e, "packet");
   endtask : pkt
   // Bounded wait for n logged frames, then room for stray extras
   task automatic settle(input int n);
      for (int k = 0; k < 300 && u_host.got.size() < n; k++)
         @(posedge mclk);
      repeat (16) @(posedge mclk);
      @(negedge mclk);
   endtask : settle
   task automatic put(input logic [8:0] f, input int n);
      u_host.send(f);
      settle(n);
   endtask : put
   task automatic flush();
      u_host.got.delete();
      u_host.tq.delete();
      pq.delete();
   endtask : flush
   task automatic talk_on();
      @(negedge mclk) talk_cmd = 1'b1;
      @(negedge mclk) talk_cmd = 1'b0;
      repeat (4) @(negedge mclk);
      cmp_v(10'(tm), 10'h001, "mode");
   endtask : talk_on
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   // Watchdog: the whole sequence needs well under 6000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      summarize();
   end
   // =====
   // Test sequence
   initial begin
      frm = 3'h4;
      fmt = {1'b1, `TPF_RST_WIDTH, 1'b0, 1'b0, 8'h02};
      esc = `TPF_RST_ESC;
      snd = `TPF_RST_SEND;
      repeat (5) @(posedge mclk);
      @(negedge mclk) rst_b = 1'b1;
      settle(1);
      out(`TPF_CH_PROMPT);
      cmp_v(10'({tm, pb}), 10'h001, "mode, dest");
      @(negedge mclk) link = 1'b1;
      settle(1);
      out(`TPF_CH_LINKUP);
      cmp_v({lamp, tm, 8'(u_host.got.size())}, 10'h300, "link");
      $display("test power-up and link done");
      put(enc(8'h48), 1);
      put(enc(8'h69), 2);
      put(enc(`TPF_CH_CR), 4);
      out(8'h48);
      out(8'h69);
      out(`TPF_CH_CR);
      out(`TPF_CH_LF);
      pkt(10'h048);
      pkt(10'h069);
      pkt(10'h100);
      @(negedge mclk) fmt.auto_linefeed = 1'b0;
      put(enc(`TPF_CH_CR), 1);
      out(`TPF_CH_CR);
      cmp_v(10'(u_host.got.size()), 10'h000, "extra");
      fmt.auto_linefeed = 1'b1;
      flush();
      put(enc(`TPF_RST_ESC), 1);
      out(`TPF_CH_PROMPT);
      cmp_v({tm, 9'(pq.size() + u_host.got.size())}, 10'h0, "esc");
      talk_on();
      u_host.brk();
      settle(1);
      out(`TPF_CH_PROMPT);
      cmp_v(10'(tm), 10'h000, "mode");
      talk_on();
      $display("test converse done");
      esc = 8'h1B;
      snd = 8'h2E;
      flush();
      put(enc(8'h03), 1);
      put(enc(8'h2E), 2);
      out(8'h03);
      out(8'h2E);
      pkt(10'h003);
      pkt(10'h100);
      put(enc(8'h1B), 1);
      out(`TPF_CH_PROMPT);
      esc = `TPF_RST_ESC;
      snd = `TPF_RST_SEND;
      link = 1'b0;
      settle(1);
      out(`TPF_CH_LINKDN);
      cmp_v(10'(lamp), 10'h000, "lamp");
      talk_on();
      flush();
      put(enc(8'h78), 1);
      pkt(10'h278);
      $display("test programmable chars done");
      put(enc(`TPF_CH_CR), 3);
      flush();
      fmt.line_width = 8'h04;
      for (i = 0; i < 4; i++) put(enc(8'h61 + 8'(i)), i + 1);
      settle(6);
      for (i = 0; i < 4; i++) out(8'h61 + 8'(i));
      out(`TPF_CH_CR);
      out(`TPF_CH_LF);
      fmt.line_width = 8'h00;
      for (i = 0; i < 5; i++) put(enc(8'h61 + 8'(i)), i + 1);
      cmp_v(10'(u_host.got.size()), 10'h005, "no wrap");
      put(enc(`TPF_CH_CR), 7);
      flush();
      fmt.pad_after_return = 1'b1;
      put(enc(`TPF_CH_CR), 2);
      i = u_host.tq[1] - u_host.tq[0];
      cmp_v(10'(i >= 80 && i <= 100), 10'h001, "return pad");
      flush();
      fmt = {1'b1, 8'h00, 1'b0, 1'b1, 8'h02};
      put(enc(`TPF_CH_CR), 2);
      put(enc(8'h7A), 3);
      i = u_host.tq[1] - u_host.tq[0];
      cmp_v(10'(i < 40), 10'h001, "no return pad");
      i = u_host.tq[2] - u_host.tq[1];
      cmp_v(10'(i >= 80), 10'h001, "linefeed pad");
      $display("test wrap and pads done");
      put(enc(`TPF_RST_ESC), 1);
      flush();
      u_host.stall = 0;
      for (i = 0; i < 4; i++) begin
         @(negedge mclk) frm = cfg[i];
         put(enc(8'h4B), 1);
         out(8'h4B);
         cmp_v(10'(perr), 10'h000, "parity flag");
         if (frm.parity != `TPF_PAR_NONE) begin
            put(enc(8'h4B) ^ (frm.wlen8 ? 9'h100 : 9'h080), 1);
            cmp_v(10'(perr), 10'h001, "parity flag");
         end
         flush();
      end
      $display("test framing done");
      summarize();
   end
endmodule : tpf_formatter_bench
`default_nettype wire
